// *** rtl/osc_pkg.sv ***
package osc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    // Ambient to lit sample spacing, 25.6 us
    localparam int SAMPLE_GAP_NS = 25600;
    localparam int SAMPLE_GAP_CYCLES = (SAMPLE_GAP_NS / CLK_PERIOD_NS < 1) ? 1 :
        SAMPLE_GAP_NS / CLK_PERIOD_NS;
    // Burst repetition period
    localparam int MEAS_PERIOD_US = 10000;
    localparam int MEAS_PERIOD_CYCLES = MEAS_PERIOD_US * 1000 / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int SAMPLE_W = 16;
    localparam int PARAM_ADDR_W = 5;
    localparam int PARAM_DEPTH = 32;
    localparam int LED_MAX = 3;
    localparam int GAP_CNT_W = 16;
    localparam int PERIOD_CNT_W = 32;

    // ------------------------------------------------------------
    // Command encoding
    // ------------------------------------------------------------
    localparam int OPC_MSB = 7;
    localparam int OPC_LSB = 5;
    localparam logic [2:0] OPC_MISC = 3'h0;
    localparam logic [2:0] OPC_QUERY = 3'h4;
    localparam logic [2:0] OPC_SET = 3'h5;
    localparam logic [4:0] MISC_NOP = 5'h00;
    localparam logic [4:0] MISC_FORCE = 5'h05;

    // ------------------------------------------------------------
    // Response encoding and parameter defaults
    // ------------------------------------------------------------
    localparam logic [7:0] RESP_RESET = 8'h00;
    localparam logic [7:0] RESP_INVALID = 8'h80;
    localparam logic [3:0] RESP_CNT_RESET = 4'h0;
    localparam logic [7:0] READ_VALUE_RESET = 8'h00;
    localparam logic [7:0] WRITE_VALUE_RESET = 8'h00;
    localparam logic [4:0] PARAM_MEAS_CTRL = 5'h00;
    localparam int MEAS_CTRL_AUTO_BIT = 0;
    localparam logic [7:0] MEAS_CTRL_RESET = 8'h01;
    localparam logic [7:0] PARAM_RESET = 8'h00;

    typedef struct packed {
        logic command_write;
        logic [7:0] command;
        logic write_value_load;
        logic [7:0] write_value;
    } osc_host_req_t;

    typedef struct packed {
        logic [7:0] response;
        logic [7:0] parameter_read_value;
        logic [7:0] parameter_write_value;
    } osc_host_view_t;

endpackage

// *** rtl/osc_ambient_sub.sv ***
`timescale 1ns/1ps
`default_nettype none

module osc_ambient_sub #(
    parameter int SAMPLE_W = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ambient_take,
    input wire logic lit_take,
    input wire logic [SAMPLE_W-1:0] level,
    output logic [SAMPLE_W-1:0] difference,
    output logic difference_valid
);
    logic [SAMPLE_W-1:0] ambient;
    logic [SAMPLE_W-1:0] next_ambient;
    logic [SAMPLE_W-1:0] next_difference;
    logic next_difference_valid;

    // ------------------------------------------------------------
    // Ambient capture and subtraction
    // ------------------------------------------------------------
    always_comb begin
        next_ambient = ambient;
        next_difference = difference;
        next_difference_valid = 1'b0;
        if (ambient_take) begin
            next_ambient = level; // R2
        end
        if (lit_take) begin
            next_difference = (level > ambient) ? level - ambient : '0; // R3
            next_difference_valid = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ambient <= '0;
            difference <= '0;
            difference_valid <= 1'b0;
        end else begin
            ambient <= next_ambient;
            difference <= next_difference;
            difference_valid <= next_difference_valid;
        end
    end

endmodule

`default_nettype wire

// *** rtl/osc_command_port.sv ***
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: Only one emitter lit at a time
// R2: Ambient sample first, then emitter-on sample
// R3: Subtract ambient, 25.6 us apart, report difference
// R4: Sequencer sleeps, wakes periodically for bursts
// R5: Register access never wakes the sequencer
// R6: Any command write wakes the sequencer
// R7: Response written after each finished command
// R8: Command during busy sequencer is dropped
// R9: Host rechecks response, rewrites dropped commands
// R10: Query command places value in read register
// R11: Set command writes value from write register
// R12: Interrupt output flags new samples ready
// R13: Read value updated before response
module osc_command_port
    import osc_pkg::*;
#(
    parameter int LED_COUNT = osc_pkg::LED_MAX,
    parameter int MEAS_PERIOD = osc_pkg::MEAS_PERIOD_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire osc_pkg::osc_host_req_t host_req,
    input wire logic [osc_pkg::SAMPLE_W-1:0] ir_level,
    input wire logic sample_read_ack,
    output osc_pkg::osc_host_view_t host_view,
    output logic [LED_COUNT-1:0] led_enable,
    output logic [LED_COUNT*osc_pkg::SAMPLE_W-1:0] reflected_light_measurement,
    output logic sample_ready,
    output logic sequencer_awake
);
    import osc_pkg::*;

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (LED_COUNT < 1 || LED_COUNT > LED_MAX) begin : g_bad_leds
        $error("LED_COUNT out of range");
    end
    if (MEAS_PERIOD < 2) begin : g_bad_period
        $error("MEAS_PERIOD too small");
    end

    typedef enum logic [2:0] {
        SEQ_STANDBY,
        SEQ_DECODE,
        SEQ_RESPOND,
        SEQ_AMBIENT,
        SEQ_LIT,
        SEQ_STORE
    } osc_seq_t;

    localparam logic [GAP_CNT_W-1:0] GAP_LOAD = GAP_CNT_W'(SAMPLE_GAP_CYCLES - 1);
    localparam logic [PERIOD_CNT_W-1:0] PERIOD_LOAD = PERIOD_CNT_W'(MEAS_PERIOD - 1);
    localparam logic [1:0] LAST_LED = 2'(LED_COUNT - 1);

    osc_seq_t state;
    osc_seq_t next_state;
    logic [7:0] command;
    logic [7:0] next_command;
    logic [3:0] resp_cnt;
    logic [3:0] next_resp_cnt;
    logic cmd_ok;
    logic next_cmd_ok;
    logic cmd_force;
    logic next_cmd_force;
    logic [1:0] led_idx;
    logic [1:0] next_led_idx;
    logic [GAP_CNT_W-1:0] gap_cnt;
    logic [GAP_CNT_W-1:0] next_gap_cnt;
    logic [PERIOD_CNT_W-1:0] period_cnt;
    logic [PERIOD_CNT_W-1:0] next_period_cnt;
    osc_host_view_t next_host_view;
    logic [LED_COUNT-1:0] next_led_enable;
    logic [LED_COUNT*SAMPLE_W-1:0] next_results;
    logic next_sample_ready;
    logic next_awake;
    logic [DATA_W-1:0] param_mem [PARAM_DEPTH];
    logic mem_we;
    logic [PARAM_ADDR_W-1:0] mem_addr;
    logic ambient_take;
    logic lit_take;
    logic [SAMPLE_W-1:0] difference;
    logic difference_valid;
    logic period_due;

    assign mem_addr = command[PARAM_ADDR_W-1:0];

    // ------------------------------------------------------------
    // Ambient subtraction unit
    // ------------------------------------------------------------
    osc_ambient_sub #(
        .SAMPLE_W(SAMPLE_W)
    ) u_sub (
        .clk(clk),
        .reset(reset),
        .ambient_take(ambient_take),
        .lit_take(lit_take),
        .level(ir_level),
        .difference(difference),
        .difference_valid(difference_valid)
    );

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_command = command;
        next_resp_cnt = resp_cnt;
        next_cmd_ok = cmd_ok;
        next_cmd_force = cmd_force;
        next_led_idx = led_idx;
        next_gap_cnt = gap_cnt;
        next_host_view = host_view;
        next_results = reflected_light_measurement;
        next_sample_ready = sample_ready;
        mem_we = 1'b0;
        ambient_take = 1'b0;
        lit_take = 1'b0;
        period_due = (period_cnt == '0);
        next_period_cnt = period_due ? PERIOD_LOAD : period_cnt - 1'b1;

        // Direct register loads, served in every state
        if (host_req.write_value_load) begin
            next_host_view.parameter_write_value = host_req.write_value; // R5
        end

        unique case (state)
            SEQ_STANDBY: begin
                if (host_req.command_write) begin
                    next_command = host_req.command; // R6
                    next_state = SEQ_DECODE;
                end else if (period_due && param_mem[PARAM_MEAS_CTRL][MEAS_CTRL_AUTO_BIT]) begin
                    next_led_idx = 2'h0; // R4
                    next_state = SEQ_AMBIENT;
                end
            end
            SEQ_DECODE: begin
                next_cmd_ok = 1'b1;
                next_cmd_force = 1'b0;
                unique case (command[OPC_MSB:OPC_LSB])
                    OPC_QUERY: begin
                        next_host_view.parameter_read_value = param_mem[mem_addr]; // R10 R13
                    end
                    OPC_SET: begin
                        mem_we = 1'b1; // R11
                    end
                    OPC_MISC: begin
                        if (command[PARAM_ADDR_W-1:0] == MISC_FORCE) begin
                            next_cmd_force = 1'b1;
                        end else if (command[PARAM_ADDR_W-1:0] != MISC_NOP) begin
                            next_cmd_ok = 1'b0;
                        end
                    end
                    default: begin
                        next_cmd_ok = 1'b0;
                    end
                endcase
                next_state = SEQ_RESPOND;
            end
            SEQ_RESPOND: begin
                if (cmd_ok) begin
                    next_resp_cnt = resp_cnt + 1'b1;
                    next_host_view.response = {4'h0, resp_cnt + 1'b1}; // R7
                end else begin
                    next_host_view.response = RESP_INVALID; // R7
                end
                next_led_idx = 2'h0;
                next_state = cmd_force ? SEQ_AMBIENT : SEQ_STANDBY;
            end
            SEQ_AMBIENT: begin
                ambient_take = 1'b1; // R2
                next_gap_cnt = GAP_LOAD;
                next_state = SEQ_LIT;
            end
            SEQ_LIT: begin
                if (gap_cnt == '0) begin
                    lit_take = 1'b1; // R3
                    next_state = SEQ_STORE;
                end else begin
                    next_gap_cnt = gap_cnt - 1'b1;
                end
            end
            SEQ_STORE: begin
                if (difference_valid) begin
                    next_results[led_idx*SAMPLE_W +: SAMPLE_W] = difference; // R3
                    if (led_idx == LAST_LED) begin
                        next_sample_ready = 1'b1; // R12
                        next_state = SEQ_STANDBY;
                    end else begin
                        next_led_idx = led_idx + 1'b1;
                        next_state = SEQ_AMBIENT;
                    end
                end
            end
        endcase

        // Commands outside standby are dropped, response untouched
        if (state != SEQ_STANDBY && host_req.command_write) begin
            next_command = next_command; // R8
        end

        // Host acknowledge clears, a new sample set wins
        if (sample_read_ack && !(state == SEQ_STORE && difference_valid && led_idx == LAST_LED)) begin
            next_sample_ready = 1'b0; // R12
        end
    end

    // ------------------------------------------------------------
    // Emitter drive and wake indication
    // ------------------------------------------------------------
    always_comb begin
        next_led_enable = '0;
        if (next_state == SEQ_LIT) begin
            next_led_enable[next_led_idx] = 1'b1; // R1
        end
        next_awake = (next_state != SEQ_STANDBY); // R5
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= SEQ_STANDBY;
            command <= 8'h00;
            resp_cnt <= RESP_CNT_RESET;
            cmd_ok <= 1'b0;
            cmd_force <= 1'b0;
            led_idx <= 2'h0;
            gap_cnt <= '0;
            period_cnt <= PERIOD_LOAD;
            host_view <= '{response: RESP_RESET, parameter_read_value: READ_VALUE_RESET,
                           parameter_write_value: WRITE_VALUE_RESET};
            led_enable <= '0;
            reflected_light_measurement <= '0;
            sample_ready <= 1'b0;
            sequencer_awake <= 1'b0;
        end else begin
            state <= next_state;
            command <= next_command;
            resp_cnt <= next_resp_cnt;
            cmd_ok <= next_cmd_ok;
            cmd_force <= next_cmd_force;
            led_idx <= next_led_idx;
            gap_cnt <= next_gap_cnt;
            period_cnt <= next_period_cnt;
            host_view <= next_host_view;
            led_enable <= next_led_enable;
            reflected_light_measurement <= next_results;
            sample_ready <= next_sample_ready;
            sequencer_awake <= next_awake;
        end
    end

    // ------------------------------------------------------------
    // Parameter memory
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < PARAM_DEPTH; i++) begin
                param_mem[i] <= (i == int'(PARAM_MEAS_CTRL)) ? MEAS_CTRL_RESET : PARAM_RESET;
            end
        end else if (mem_we) begin
            param_mem[mem_addr] <= host_view.parameter_write_value; // R11
        end
    end

endmodule

`default_nettype wire

// *** rtl/osc_unused_placeholder_removed.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** tb/osc_command_port_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// Checks
// ----
module osc_command_port_asserts
    import osc_pkg::*;
#(
    parameter int LED_COUNT = 3,
    parameter int MEAS_PERIOD = 2000
) (
    input wire logic clk,
    input wire logic reset,
    input wire osc_pkg::osc_host_req_t host_req,
    input wire logic [osc_pkg::SAMPLE_W-1:0] ir_level,
    input wire logic sample_read_ack,
    input wire osc_pkg::osc_host_view_t host_view,
    input wire logic [LED_COUNT-1:0] led_enable,
    input wire logic [LED_COUNT*osc_pkg::SAMPLE_W-1:0] reflected_light_measurement,
    input wire logic sample_ready,
    input wire logic sequencer_awake
);
    logic [15:0] lit_cnt;
    logic [15:0] next_lit_cnt;
    logic taken;
    assign taken = host_req.command_write && !sequencer_awake;
    always_comb begin
        next_lit_cnt = (|led_enable) ? lit_cnt + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lit_cnt <= 16'h0000;
        end else begin
            lit_cnt <= next_lit_cnt;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_one_led: assert property ($onehot0(led_enable))
        else $error("two emitters lit");
    a_lit_span: assert property ($fell(|led_enable) |-> lit_cnt == 16'(SAMPLE_GAP_CYCLES))
        else $error("lit span wrong");
    a_dark_standby: assert property (!sequencer_awake |-> led_enable == '0)
        else $error("emitter lit in standby");
    a_cmd_wakes: assert property (taken |=> sequencer_awake)
        else $error("command did not wake");
    a_query_answered: assert property (taken && host_req.command[7:5] == OPC_QUERY
        |-> ##[1:4] $changed(host_view.response))
        else $error("query not answered");
    a_resp_needs_wake: assert property ($changed(host_view.response) |-> $past(sequencer_awake))
        else $error("response moved while asleep");
    a_read_first: assert property ($changed(host_view.response)
        |-> $stable(host_view.parameter_read_value))
        else $error("read value late");
    a_load_value: assert property (host_req.write_value_load
        |=> host_view.parameter_write_value == $past(host_req.write_value))
        else $error("write value not loaded");
    a_ready_at_end: assert property ($rose(sample_ready) |-> $fell(sequencer_awake))
        else $error("ready not at burst end");
    a_ack_clears: assert property (sample_read_ack && !sequencer_awake |=> !sample_ready)
        else $error("ack did not clear");
    c_taken: cover property (taken);
    c_dropped: cover property (host_req.command_write && sequencer_awake);
    c_ready: cover property ($rose(sample_ready));
endmodule

bind osc_command_port osc_command_port_asserts #(
    .LED_COUNT(LED_COUNT),
    .MEAS_PERIOD(MEAS_PERIOD)
) u_chk (
    .clk(clk),
    .reset(reset),
    .host_req(host_req),
    .ir_level(ir_level),
    .sample_read_ack(sample_read_ack),
    .host_view(host_view),
    .led_enable(led_enable),
    .reflected_light_measurement(reflected_light_measurement),
    .sample_ready(sample_ready),
    .sequencer_awake(sequencer_awake)
);
`default_nettype wire

// *** tb/osc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// Host side
// ----
module osc_host_model
    import osc_pkg::*;
(
    input wire logic clk,
    output osc_pkg::osc_host_req_t host_req,
    input wire osc_pkg::osc_host_view_t host_view,
    input wire logic sequencer_awake
);
    initial host_req = '0;
    task automatic put(input logic [7:0] c);
        @(negedge clk);
        host_req.command_write = 1'b1;
        host_req.command = c;
    endtask
    task automatic load(input logic [7:0] v);
        @(negedge clk);
        host_req.write_value_load = 1'b1;
        host_req.write_value = v;
    endtask
    // Released lines show the inverse
    task automatic idle;
        @(negedge clk);
        host_req.command_write = 1'b0;
        host_req.write_value_load = 1'b0;
        host_req.command = ~host_req.command;
        host_req.write_value = ~host_req.write_value;
    endtask
    // Command, then response watch, rewritten while refused
    task automatic post(input logic [7:0] c, output logic [7:0] r);
        logic [7:0] old;
        old = host_view.response;
        for (int i = 0; i < 400; i++) begin
            if (host_view.response !== old) break;
            if (!sequencer_awake) begin
                put(c);
                idle();
            end
            repeat (4) @(negedge clk);
        end
        r = host_view.response;
    endtask
endmodule
`default_nettype wire

// *** tb/optical_sensor_command_port_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench
// ----
module optical_sensor_command_port_test;
    import osc_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [SAMPLE_W-1:0] ir_level = '0;
    logic sample_read_ack = 1'b0;
    osc_host_req_t host_req;
    osc_host_view_t host_view;
    logic [2:0] led_enable;
    logic [47:0] meas;
    logic sample_ready;
    logic sequencer_awake;
    int err_count = 0;
    int compares = 0;
    logic [3:0] cnt = 4'h0;
    logic [7:0] r;

    osc_command_port #(.LED_COUNT(3), .MEAS_PERIOD(2000)) uut (
        .clk(clk),
        .reset(reset),
        .host_req(host_req),
        .ir_level(ir_level),
        .sample_read_ack(sample_read_ack),
        .host_view(host_view),
        .led_enable(led_enable),
        .reflected_light_measurement(meas),
        .sample_ready(sample_ready),
        .sequencer_awake(sequencer_awake)
    );
    osc_host_model host (
        .clk(clk),
        .host_req(host_req),
        .host_view(host_view),
        .sequencer_awake(sequencer_awake)
    );

    initial begin
        forever #20 clk = ~clk;
    end
    // Ambient 0x100; third emitter reads below ambient
    always @(negedge clk) begin
        ir_level <= led_enable[0] ? 16'h0110 : led_enable[1] ? 16'h0120 :
            led_enable[2] ? 16'h00f0 : 16'h0100;
    end

    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic t_reset_query;
        check("response", host_view.response, RESP_RESET);
        check("awake", sequencer_awake, 1'b0);
        host.post(8'h80, r);
        cnt++;
        check("response", r, {4'h0, cnt});
        check("read value", host_view.parameter_read_value, MEAS_CTRL_RESET);
    endtask

    task automatic t_set_query;
        host.load(8'h5a);
        host.idle();
        check("write value", host_view.parameter_write_value, 8'h5a);
        check("awake", sequencer_awake, 1'b0);
        host.post(8'ha3, r);
        cnt++;
        check("response", r, {4'h0, cnt});
        host.post(8'h83, r);
        cnt++;
        check("read value", host_view.parameter_read_value, 8'h5a);
        host.load(8'h00);
        host.idle();
        host.post(8'ha0, r);
        cnt++;
        check("response", r, {4'h0, cnt});
    endtask

    task automatic t_busy_drop;
        host.put(8'h84);
        host.put(8'h83);
        host.idle();
        repeat (5) @(negedge clk);
        cnt++;
        check("response", host_view.response, {4'h0, cnt});
        check("read value", host_view.parameter_read_value, PARAM_RESET);
    endtask

    task automatic t_invalid;
        host.put(8'he0);
        host.idle();
        repeat (5) @(negedge clk);
        check("response", host_view.response, RESP_INVALID);
        host.post(8'h00, r);
        cnt++;
        check("response", r, {4'h0, cnt});
    endtask

    task automatic t_burst;
        host.post(8'h05, r);
        cnt++;
        check("response", r, {4'h0, cnt});
        for (int i = 0; i < 3000 && sample_ready !== 1'b1; i++) @(negedge clk);
        check("ready", sample_ready, 1'b1);
        check("awake", sequencer_awake, 1'b0);
        check("results", meas, 48'h0000_0020_0010);
        @(negedge clk);
        sample_read_ack = 1'b1;
        @(negedge clk);
        sample_read_ack = 1'b0;
        check("ready", sample_ready, 1'b0);
    endtask

    initial begin
        repeat (3) @(negedge clk);
        reset = 1'b0;
        t_reset_query();
        t_set_query();
        t_busy_drop();
        t_invalid();
        t_burst();
        end_of_test();
    end
    initial begin
        #(40 * 20000);
        err_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
